/* spm_pkg.sv */
// Purpose: Constants for the shared pin I/O multiplexer.
// Assumes: 16-bit data-memory bus with word addresses.
// Notes: Reset values leave every shared pin as a general-purpose input except port C line 1 if a clock is chosen and lines 2-3, whose selects are inverted.
package spm_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [15:0] PIN_SELECT_A_ADDR = 16'h7090;
  localparam logic [15:0] PIN_SELECT_B_ADDR = 16'h7092;
  localparam logic [15:0] PORT_A_ADDR = 16'h7098;
  localparam logic [15:0] PORT_B_ADDR = 16'h709A;
  localparam logic [15:0] PORT_C_ADDR = 16'h709C;

  // ----------------------------------------
  // Implemented bit masks
  // ----------------------------------------
  localparam logic [15:0] PIN_SELECT_A_MASK = 16'hFF0F;
  localparam logic [15:0] PIN_SELECT_B_MASK = 16'h00FD;
  localparam logic [15:0] PORT_A_MASK = 16'h0F0F;
  localparam logic [15:0] PORT_FULL_MASK = 16'hFFFF;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DATA_LSB = 0;
  localparam int DIR_LSB = 8;
  localparam int PORT_B_SEL_LSB = 8;
  localparam int CLOCK_PIN_LINE = 1;

  // ----------------------------------------
  // Clock pin source codes
  // ----------------------------------------
  localparam logic [1:0] CLK_SEL_GPIO = 2'h0;
  localparam logic [1:0] CLK_SEL_WATCHDOG = 2'h1;
  localparam logic [1:0] CLK_SEL_SYSTEM = 2'h2;
  localparam logic [1:0] CLK_SEL_CORE = 2'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] PIN_SELECT_A_RESET = 16'h0000;
  localparam logic [15:0] PIN_SELECT_B_RESET = 16'h0000;
  localparam logic [15:0] PORT_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;

endpackage

/* spm_shared_pin_io_mux.sv */
// Purpose: Shared pin multiplexer and general-purpose I/O for ports A, B, C.
// Assumes: Pad inputs and peripheral signals are synchronous to clk.
// Notes: Read data appears one clock after the read strobe.
`timescale 1ns/1ps

module spm_shared_pin_io_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data-memory bus
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWrData,
  input wire logic memWrite,
  input wire logic memRead,
  output logic [15:0] memRdData,
  // Clock pin source select from system control bits 7-6
  input wire logic [1:0] clockOutSelect,
  // Clock sources for the clock pin
  input wire logic watchdogClock,
  input wire logic systemClock,
  input wire logic coreClock,
  // Port A pads
  input wire logic [3:0] portAPinIn,
  output logic [3:0] portAPinOut,
  output logic [3:0] portAPinOe,
  // Port A peripheral side (analog channels)
  input wire logic [3:0] portAPeriphOut,
  input wire logic [3:0] portAPeriphOe,
  output logic [3:0] portAPeriphIn,
  // Port B pads
  input wire logic [7:0] portBPinIn,
  output logic [7:0] portBPinOut,
  output logic [7:0] portBPinOe,
  // Port B peripheral side (compare, timer)
  input wire logic [7:0] portBPeriphOut,
  input wire logic [7:0] portBPeriphOe,
  output logic [7:0] portBPeriphIn,
  // Port C pads
  input wire logic [7:0] portCPinIn,
  output logic [7:0] portCPinOut,
  output logic [7:0] portCPinOe,
  // Port C peripheral side (trigger, flag, branch, capture)
  input wire logic [7:0] portCPeriphOut,
  input wire logic [7:0] portCPeriphOe,
  output logic [7:0] portCPeriphIn
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Merge a bus write into the implemented bits only
  function automatic logic [15:0] maskWrite(input logic [15:0] wdata,
                                            input logic [15:0] mask);
    maskWrite = wdata & mask;
  endfunction

  // Data field reads the pad in input mode, the latch in output mode
  function automatic logic [15:0] readPort(input logic [15:0] regValue,
                                           input logic [7:0] pinLevel,
                                           input logic [15:0] mask);
    logic [7:0] dirBits;
    logic [7:0] dataBits;
    dirBits = regValue[spm_pkg::DIR_LSB +: 8];
    dataBits = (regValue[spm_pkg::DATA_LSB +: 8] & dirBits) | (pinLevel & ~dirBits);
    readPort = {dirBits, dataBits} & mask;
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] pinSelectA_q;
  logic [15:0] pinSelectB_q;
  logic [15:0] portALevelDir_q;
  logic [15:0] portBLevelDir_q;
  logic [15:0] portCLevelDir_q;
  logic [15:0] memRdData_d;

  // Address decode
  logic hitSelA;
  logic hitSelB;
  logic hitPortA;
  logic hitPortB;
  logic hitPortC;

  // Per-pin primary-function selects, one bit per pin
  logic [3:0] primaryA;
  logic [7:0] primaryB;
  logic [7:0] primaryC;

  // Clock pin drive value
  logic clockPinValue;

  // Plain word decode on the data-memory bus
  assign hitSelA = memAddr == spm_pkg::PIN_SELECT_A_ADDR;
  assign hitSelB = memAddr == spm_pkg::PIN_SELECT_B_ADDR;
  assign hitPortA = memAddr == spm_pkg::PORT_A_ADDR;
  assign hitPortB = memAddr == spm_pkg::PORT_B_ADDR;
  assign hitPortC = memAddr == spm_pkg::PORT_C_ADDR;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------

  // Mux register A: port A and port B pin selects
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinSelectA_q <= spm_pkg::PIN_SELECT_A_RESET;
    end else if (memWrite && hitSelA) begin
      pinSelectA_q <= maskWrite(memWrData, spm_pkg::PIN_SELECT_A_MASK);
    end
  end

  // Mux register B: port C pin selects; bit 1 unused, clock pin is elsewhere
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinSelectB_q <= spm_pkg::PIN_SELECT_B_RESET;
    end else if (memWrite && hitSelB) begin
      pinSelectB_q <= maskWrite(memWrData, spm_pkg::PIN_SELECT_B_MASK);
    end
  end

  // Port A latch; only four lines exist, upper nibbles stay zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      portALevelDir_q <= spm_pkg::PORT_RESET;
    end else if (memWrite && hitPortA) begin
      portALevelDir_q <= maskWrite(memWrData, spm_pkg::PORT_A_MASK);
    end
  end

  // Port B latch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      portBLevelDir_q <= spm_pkg::PORT_RESET;
    end else if (memWrite && hitPortB) begin
      portBLevelDir_q <= maskWrite(memWrData, spm_pkg::PORT_FULL_MASK);
    end
  end

  // Port C latch; the data written is kept even while a line is an input
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      portCLevelDir_q <= spm_pkg::PORT_RESET;
    end else if (memWrite && hitPortC) begin
      portCLevelDir_q <= maskWrite(memWrData, spm_pkg::PORT_FULL_MASK);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------

  // Read mux; unmapped addresses answer zero
  always_comb begin
    memRdData_d = spm_pkg::READ_IDLE;
    if (hitSelA) begin
      memRdData_d = pinSelectA_q;
    end else if (hitSelB) begin
      memRdData_d = pinSelectB_q;
    end else if (hitPortA) begin
      memRdData_d = readPort(portALevelDir_q, {4'h0, portAPinIn}, spm_pkg::PORT_A_MASK);
    end else if (hitPortB) begin
      memRdData_d = readPort(portBLevelDir_q, portBPinIn, spm_pkg::PORT_FULL_MASK);
    end else if (hitPortC) begin
      memRdData_d = readPort(portCLevelDir_q, portCPinIn, spm_pkg::PORT_FULL_MASK);
    end
  end

  // Registered read data, so pad levels are sampled once per access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memRdData <= spm_pkg::READ_IDLE;
    end else if (memRead) begin
      memRdData <= memRdData_d;
    end
  end

  // ----------------------------------------
  // Function selection
  // ----------------------------------------

  // Port A: analog channels 0, 1, 9, 8 when the select bit is set
  assign primaryA = pinSelectA_q[3:0];

  // Port B: compare, timer compare, timer direction and clock inputs
  assign primaryB = pinSelectA_q[spm_pkg::PORT_B_SEL_LSB +: 8];

  // Port C: line 0 trigger, lines 2-3 inverted, line 1 clock pin, 4-7 capture
  always_comb begin
    primaryC = 8'h00;
    primaryC[0] = pinSelectB_q[0];
    primaryC[1] = clockOutSelect != spm_pkg::CLK_SEL_GPIO;
    primaryC[2] = ~pinSelectB_q[2];
    primaryC[3] = ~pinSelectB_q[3];
    primaryC[7:4] = pinSelectB_q[7:4];
  end

  // Clock pin source; a glitch on switching is the caller's concern
  always_comb begin
    clockPinValue = 1'b0;
    unique case (clockOutSelect)
      spm_pkg::CLK_SEL_WATCHDOG: clockPinValue = watchdogClock;
      spm_pkg::CLK_SEL_SYSTEM: clockPinValue = systemClock;
      spm_pkg::CLK_SEL_CORE: clockPinValue = coreClock;
      spm_pkg::CLK_SEL_GPIO: clockPinValue = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Pad drive
  // ----------------------------------------

  // Port A pads: peripheral owns the pad when selected, else the latch
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (primaryA[i]) begin
        portAPinOut[i] = portAPeriphOut[i];
        portAPinOe[i] = portAPeriphOe[i];
      end else begin
        portAPinOut[i] = portALevelDir_q[spm_pkg::DATA_LSB + i];
        portAPinOe[i] = portALevelDir_q[spm_pkg::DIR_LSB + i];
      end
    end
  end

  // Port B pads
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (primaryB[i]) begin
        portBPinOut[i] = portBPeriphOut[i];
        portBPinOe[i] = portBPeriphOe[i];
      end else begin
        portBPinOut[i] = portBLevelDir_q[spm_pkg::DATA_LSB + i];
        portBPinOe[i] = portBLevelDir_q[spm_pkg::DIR_LSB + i];
      end
    end
  end

  // Port C pads; the clock pin is always driven while a clock is chosen
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i == spm_pkg::CLOCK_PIN_LINE && primaryC[i]) begin
        portCPinOut[i] = clockPinValue;
        portCPinOe[i] = 1'b1;
      end else if (primaryC[i]) begin
        portCPinOut[i] = portCPeriphOut[i];
        portCPinOe[i] = portCPeriphOe[i];
      end else begin
        portCPinOut[i] = portCLevelDir_q[spm_pkg::DATA_LSB + i];
        portCPinOe[i] = portCLevelDir_q[spm_pkg::DIR_LSB + i];
      end
    end
  end

  // ----------------------------------------
  // Peripheral inputs
  // ----------------------------------------

  // Peripherals see the pad only when they own it, so a GPIO line
  // toggling cannot fake a capture edge or a timer clock
  assign portAPeriphIn = portAPinIn & primaryA;
  assign portBPeriphIn = portBPinIn & primaryB;
  assign portCPeriphIn = portCPinIn & primaryC;

  // Serial, SPI and interrupt pins keep their I/O control inside their
  // own peripherals and never pass through this block

endmodule

/* spm_pin_board.sv */
// Purpose: Board model that resolves the level on every shared pad.
// Assumes: A pad not driven by the block is held by the board level.
// Notes: Board drivers stand in for pull resistors and external parts.
`timescale 1ns/1ps

module spm_pin_board (
  // Block drive
  input wire logic [3:0] portAPinOut,
  input wire logic [3:0] portAPinOe,
  input wire logic [7:0] portBPinOut,
  input wire logic [7:0] portBPinOe,
  input wire logic [7:0] portCPinOut,
  input wire logic [7:0] portCPinOe,
  // Board drive
  input wire logic [3:0] boardA,
  input wire logic [7:0] boardB,
  input wire logic [7:0] boardC,
  // Pad levels
  output logic [3:0] portAPinIn,
  output logic [7:0] portBPinIn,
  output logic [7:0] portCPinIn
);
  // Block wins where it drives, so a board fight never shows as a level
  assign portAPinIn = (portAPinOe & portAPinOut) | (~portAPinOe & boardA);
  assign portBPinIn = (portBPinOe & portBPinOut) | (~portBPinOe & boardB);
  assign portCPinIn = (portCPinOe & portCPinOut) | (~portCPinOe & boardC);
endmodule

/* spm_mux_sva.sv */
// Purpose: Port checks for the shared pin multiplexer.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes: Attached by bind at the foot of this file.
`timescale 1ns/1ps

module spm_mux_sva (
  // Clock and bus
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWrData,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic [15:0] memRdData,
  // Clock pin
  input wire logic [1:0] clockOutSelect,
  input wire logic watchdogClock,
  input wire logic systemClock,
  input wire logic coreClock,
  input wire logic [7:0] portCPinOut,
  input wire logic [7:0] portCPinOe,
  // Port A pads
  input wire logic [3:0] portAPinIn,
  input wire logic [3:0] portAPinOut,
  input wire logic [3:0] portAPeriphOut,
  input wire logic [3:0] portAPeriphIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Clock pin source and drive
  wdog_pin_a: assert property (clockOutSelect == 2'h1 |-> portCPinOe[1] &&
    portCPinOut[1] == watchdogClock) else $error("watchdog clock not on pin");
  sys_pin_a: assert property (clockOutSelect == 2'h2 |-> portCPinOe[1] &&
    portCPinOut[1] == systemClock) else $error("system clock not on pin");
  core_pin_a: assert property (clockOutSelect == 2'h3 |-> portCPinOe[1] &&
    portCPinOut[1] == coreClock) else $error("core clock not on pin");
  // Bus read side
  unmapped_read_a: assert property (memRead && !(memAddr inside {16'h7090, 16'h7092,
    16'h7098, 16'h709A, 16'h709C}) |=> memRdData == 16'h0000) else $error("unmapped read");
  read_hold_a: assert property (!memRead |=> $stable(memRdData))
    else $error("read data moved");
  sela_mask_a: assert property (memRead && memAddr == 16'h7090 |=>
    (memRdData & 16'h00F0) == 16'h0000) else $error("select A gap bits");
  selb_mask_a: assert property (memRead && memAddr == 16'h7092 |=>
    (memRdData & 16'hFF02) == 16'h0000) else $error("select B gap bits");
  wr_rd_a: assert property (memWrite && memAddr == 16'h7090 ##1
    memRead && !memWrite && memAddr == 16'h7090 |=>
    memRdData == ($past(memWrData, 2) & 16'hFF0F)) else $error("write then read");
  // Port A peripheral side sees the pad only when it owns the pin
  periph_own_a: assert property (((portAPeriphIn & ~portAPinIn) |
    (portAPeriphIn & (portAPinOut ^ portAPeriphOut))) == 4'h0) else $error("ownership");
endmodule

bind spm_shared_pin_io_mux spm_mux_sva spm_mux_sva_i (.*);

/* spm_shared_pin_io_mux_test.sv */
// Purpose: Self-checking bench for the shared pin multiplexer.
// Assumes: Inputs change at the falling edge.
// Notes: Register read data is checked one clock after the strobe.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module spm_shared_pin_io_mux_test;
  logic clk, reset_n, memWrite, memRead, watchdogClock, systemClock, coreClock;
  logic [15:0] memAddr, memWrData, memRdData;
  logic [1:0] clockOutSelect;
  logic [3:0] portAPinIn, portAPinOut, portAPinOe, portAPeriphOut, portAPeriphOe;
  logic [3:0] portAPeriphIn, boardA;
  logic [7:0] portBPinIn, portBPinOut, portBPinOe, portBPeriphOut, portBPeriphOe;
  logic [7:0] portBPeriphIn, boardB, portCPinIn, portCPinOut, portCPinOe;
  logic [7:0] portCPeriphOut, portCPeriphOe, portCPeriphIn, boardC;
  int errorCnt = 0;
  int cmpCount = 0;

  spm_shared_pin_io_mux spm_shared_pin_io_mux_i (.*);
  spm_pin_board spm_pin_board_i (.*);

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Bus write; the strobe is left for the next access to change, so two
  // accesses in a row never assign a strobe twice in one time step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    memAddr = a;
    memWrData = d;
    memWrite = 1'b1;
    memRead = 1'b0;
    @(negedge clk);
  endtask

  // Bus read and compare; data stands until the next read edge
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    memAddr = a;
    memRead = 1'b1;
    memWrite = 1'b0;
    @(negedge clk);
    `CHK("memRdData", e, memRdData)
  endtask

  task automatic resetValues;
    rd(16'h7090, 16'h0000);
    rd(16'h7092, 16'h0000);
    rd(16'h7098, {12'h000, boardA});
    rd(16'h709A, {8'h00, boardB});
    rd(16'h709C, {8'h00, boardC});
    rd(16'h7094, 16'h0000);
    `CHK("portAPinOe", 4'h0, portAPinOe)
  endtask

  task automatic gpioOut;
    wr(16'h7098, 16'h0F05);
    `CHK("portAPinOe", 4'hF, portAPinOe)
    `CHK("portAPinOut", 4'h5, portAPinOut)
    rd(16'h7098, 16'h0F05);
    // Mixed direction: low lines from the latch, high lines from the pads
    wr(16'h709A, 16'h0F3C);
    rd(16'h709A, 16'h0F5C);
    wr(16'h7094, 16'hFFFF);
    rd(16'h7094, 16'h0000);
  endtask

  task automatic primary;
    portAPeriphOut = 4'h3;
    portAPeriphOe = 4'hF;
    portBPeriphOut = 8'h96;
    portBPeriphOe = 8'hFF;
    wr(16'h7090, 16'hFFFF);
    rd(16'h7090, 16'hFF0F);
    `CHK("portAPinOut", 4'h3, portAPinOut)
    `CHK("portAPeriphIn", 4'h3, portAPeriphIn)
    `CHK("portBPinOut", 8'h96, portBPinOut)
    `CHK("portBPinOe", 8'hFF, portBPinOe)
    `CHK("portBPeriphIn", 8'h96, portBPeriphIn)
    wr(16'h7090, 16'h0000);
    `CHK("portAPeriphIn", 4'h0, portAPeriphIn)
    `CHK("portBPeriphIn", 8'h00, portBPeriphIn)
    `CHK("portBPinOe", 8'h0F, portBPinOe)
    `CHK("portAPinOut", 4'h5, portAPinOut)
  endtask

  task automatic portC;
    portCPeriphOut = 8'hA5;
    portCPeriphOe = 8'hFF;
    wr(16'h7092, 16'hFFFF);
    rd(16'h7092, 16'h00FD);
    wr(16'h709C, 16'hFF0C);
    `CHK("portCPinOut", 8'hAD, portCPinOut)
    `CHK("portCPinOe", 8'hFF, portCPinOe)
    `CHK("portCPeriphIn", 8'hA1, portCPeriphIn)
    wr(16'h7092, 16'h0000);
    `CHK("portCPinOut", 8'h04, portCPinOut)
    `CHK("portCPeriphIn", 8'h04, portCPeriphIn)
  endtask

  // Every source code, under every mix of source levels
  task automatic clockPin;
    logic [2:0] v;
    memWrite = 1'b0; // Close the last write of the port C scenario
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 8; p++) begin
        v = 3'(p);
        clockOutSelect = 2'(k);
        {coreClock, systemClock, watchdogClock} = v;
        #1;
        `CHK("clockPin", (k == 0) ? 1'b0 : v[k-1], portCPinOut[1])
        `CHK("clockOe", 1'b1, portCPinOe[1])
        @(negedge clk);
      end
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {reset_n, memWrite, memRead, watchdogClock, systemClock, coreClock} = 6'h00;
    {memAddr, memWrData, clockOutSelect} = 34'h0;
    {portAPeriphOut, portAPeriphOe, portBPeriphOut, portBPeriphOe} = 24'h0;
    {portCPeriphOut, portCPeriphOe} = 16'h0;
    boardA = 4'hA;
    boardB = 8'h5A;
    boardC = 8'hC3;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    resetValues();
    gpioOut();
    primary();
    portC();
    clockPin();
    give_verdict();
  end
endmodule
